//--- logic/tacc_config_ctrl.v
// Overview of operation
// - Hysteresis lowers every limit for falling temperature only; rising trips plainly.
// - Upper and critical comparator alarms hold until temperature falls below limit minus hysteresis.
// - Upper status bit 14 sets above upper limit, clears below limit minus hysteresis.
// - In comparator mode the alert pin release uses the same hysteresis thresholds as the status bits.
// - Either lock freezes hysteresis, sensor off, output enable, polarity and mode.
// - Bit 8 zero runs continuous conversion, one turns the sensor off.
// - Sensor off: no temperature updates, no alerts, alert pin released.
// - Bit 7 critical lock blocks critical trip register updates when set.
// - Critical lock cannot be cleared by software, only by power-on reset.
// - Bit 6 window lock blocks upper and lower trip register updates.
// - Window lock cannot be cleared by software, only by power-on reset.
// - Bit 5 release is write-only, reads zero; writing one frees interrupt alert.
// - Release writes are ignored in comparator mode.
// - Bit 4 reads one while the alert output is asserted by an alarm.
// - Asserted flag clears in sensor off; in comparator mode it resumes at once when on again.
// - Bit 3 zero keeps the alert pin quiet, one lets it assert.
// - Bit 2 zero: all alarms alert; one: only the critical alarm alerts.
// - Window lock alone freezes the critical-only field.
// - Bit 1 zero makes the alert active low, one active high.
// - Bit 0 zero selects comparator mode, one interrupt mode.
// - Bits 10:9 select hysteresis: off, 1.5, 3.0 or 6.0 degrees.
`timescale 1ns/1ps
`default_nettype none
`include "tacc_map.vh"

module tacc_config_ctrl #(
   parameter TW = `TACC_TEMP_W
) (
   input wire mclk,
   input wire arst_n,
   input wire cfg_wr,
   input wire [15:0] cfg_wdata,
   output reg [15:0] cfg_rdata,
   input wire temp_valid,
   input wire [TW-1:0] temp_sample,
   input wire [TW-1:0] upper_limit,
   input wire [TW-1:0] lower_limit,
   input wire [TW-1:0] crit_limit,
   output reg [15:0] temp_rdata,
   output wire conv_enable,
   input wire crit_trip_wr,
   output wire crit_trip_wr_ok,
   input wire window_trip_wr,
   output wire window_trip_wr_ok,
   input wire alert_i,
   output reg alert_o,
   output reg alert_oe_n
);

   // Hysteresis amount for a select code
   function [TW-1:0] hyst_amount;
      input [1:0] sel;
      begin
         case (sel)
            `TACC_HYST_1P5: hyst_amount = `TACC_HYST_AMT_1P5;
            `TACC_HYST_3P0: hyst_amount = `TACC_HYST_AMT_3P0;
            `TACC_HYST_6P0: hyst_amount = `TACC_HYST_AMT_6P0;
            default: hyst_amount = `TACC_HYST_AMT_OFF;
         endcase
      end
   endfunction

   reg rst_meta_q;
   reg rst_n_q;

   reg [1:0] hyst_sel_q;
   reg sensor_off_q;
   reg crit_lock_q;
   reg win_lock_q;
   reg alert_oe_q;
   reg crit_only_q;
   reg alert_pol_q;
   reg alert_mode_q;

   reg [1:0] hyst_sel_d;
   reg sensor_off_d;
   reg alert_oe_d;
   reg crit_only_d;
   reg alert_pol_d;
   reg alert_mode_d;

   reg [TW-1:0] temp_q;
   reg cond_prev_q;
   reg int_latch_q;
   reg int_latch_d;
   reg alert_flag_q;
   reg alert_flag_d;

   wire any_lock;
   wire sample;
   wire [TW-1:0] hyst_val;
   wire crit_alarm;
   wire high_alarm;
   wire low_alarm;
   wire alert_cond;
   wire alert_rise;
   wire release_req;
   wire alert_sync_unused;

   // Reset is released through two flops
   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   assign any_lock = crit_lock_q | win_lock_q;
   assign hyst_val = hyst_amount(hyst_sel_q);
   assign conv_enable = ~sensor_off_q;
   assign sample = temp_valid & ~sensor_off_q;
   assign alert_sync_unused = alert_i;

   // Trip register writes pass only while their lock is clear
   assign crit_trip_wr_ok = crit_trip_wr & ~crit_lock_q;
   assign window_trip_wr_ok = window_trip_wr & ~win_lock_q;

   // Field updates on a configuration write
   always @*
   begin
      hyst_sel_d = hyst_sel_q;
      sensor_off_d = sensor_off_q;
      alert_oe_d = alert_oe_q;
      crit_only_d = crit_only_q;
      alert_pol_d = alert_pol_q;
      alert_mode_d = alert_mode_q;
      if (cfg_wr && !any_lock)
      begin
         hyst_sel_d = cfg_wdata[`TACC_CFG_HYST_HI:`TACC_CFG_HYST_LO];
         sensor_off_d = cfg_wdata[`TACC_CFG_OFF];
         alert_oe_d = cfg_wdata[`TACC_CFG_OE];
         alert_pol_d = cfg_wdata[`TACC_CFG_POL];
         alert_mode_d = cfg_wdata[`TACC_CFG_MODE];
      end
      if (cfg_wr && !win_lock_q)
         crit_only_d = cfg_wdata[`TACC_CFG_CRIT];
   end

   always @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         hyst_sel_q <= `TACC_RST_HYST;
         sensor_off_q <= `TACC_RST_BIT;
         alert_oe_q <= `TACC_RST_BIT;
         crit_only_q <= `TACC_RST_BIT;
         alert_pol_q <= `TACC_RST_BIT;
         alert_mode_q <= `TACC_RST_BIT;
      end
      else
      begin
         hyst_sel_q <= hyst_sel_d;
         sensor_off_q <= sensor_off_d;
         alert_oe_q <= alert_oe_d;
         crit_only_q <= crit_only_d;
         alert_pol_q <= alert_pol_d;
         alert_mode_q <= alert_mode_d;
      end
   end

   // Locks only ever set; only the power-on reset clears them
   always @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         crit_lock_q <= `TACC_RST_BIT;
         win_lock_q <= `TACC_RST_BIT;
      end
      else if (cfg_wr)
      begin
         crit_lock_q <= crit_lock_q | cfg_wdata[`TACC_CFG_CLOCK];
         win_lock_q <= win_lock_q | cfg_wdata[`TACC_CFG_WLOCK];
      end
   end

   // Temperature data frozen while the sensor is off
   always @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
         temp_q <= {TW{1'b0}};
      else if (sample)
         temp_q <= temp_sample;
   end

   tacc_alarm_cmp #(
      .W(TW),
      .LOWER(0)
   ) u_crit (
      .clk(mclk),
      .rst_n(rst_n_q),
      .sample(sample),
      .temp(temp_sample),
      .limit(crit_limit),
      .hyst(hyst_val),
      .alarm_q(crit_alarm)
   );

   // Upper alarm also drives temperature status bit 14
   tacc_alarm_cmp #(
      .W(TW),
      .LOWER(0)
   ) u_high (
      .clk(mclk),
      .rst_n(rst_n_q),
      .sample(sample),
      .temp(temp_sample),
      .limit(upper_limit),
      .hyst(hyst_val),
      .alarm_q(high_alarm)
   );

   tacc_alarm_cmp #(
      .W(TW),
      .LOWER(1)
   ) u_low (
      .clk(mclk),
      .rst_n(rst_n_q),
      .sample(sample),
      .temp(temp_sample),
      .limit(lower_limit),
      .hyst(hyst_val),
      .alarm_q(low_alarm)
   );

   // Alert source from the same hysteresis-qualified alarms as the status bits
   assign alert_cond = crit_only_q ? crit_alarm
                     : (crit_alarm | high_alarm | low_alarm);

   assign alert_rise = alert_cond & ~cond_prev_q;

   // Release honoured only in interrupt mode
   assign release_req = cfg_wr & cfg_wdata[`TACC_CFG_REL] & alert_mode_q;

   always @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
         cond_prev_q <= 1'b0;
      else
         cond_prev_q <= alert_cond;
   end

   // Interrupt latch: a new alarm edge beats a release in the same cycle
   always @*
   begin
      int_latch_d = int_latch_q;
      if (sensor_off_q || !alert_oe_q || !alert_mode_q)
         int_latch_d = 1'b0;
      else if (alert_rise)
         int_latch_d = 1'b1;
      else if (release_req)
         int_latch_d = 1'b0;
   end

   always @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
         int_latch_q <= 1'b0;
      else
         int_latch_q <= int_latch_d;
   end

   // Asserted flag, cleared while the sensor is off
   always @*
   begin
      alert_flag_d = 1'b0;
      if (!sensor_off_q && alert_oe_q)
      begin
         if (alert_mode_q)
            alert_flag_d = int_latch_q;
         else
            alert_flag_d = alert_cond;
      end
   end

   always @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
         alert_flag_q <= `TACC_RST_BIT;
      else
         alert_flag_q <= alert_flag_d;
   end

   // Pin is driven only while asserted; otherwise the pull-up sets the level
   always @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         alert_o <= 1'b0;
         alert_oe_n <= 1'b1;
      end
      else
      begin
         alert_o <= alert_pol_d;
         alert_oe_n <= ~alert_flag_d;
      end
   end

   // Register read images; reserved and release bits read zero
   always @(posedge mclk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         cfg_rdata <= `TACC_RST_WORD;
         temp_rdata <= `TACC_RST_WORD;
      end
      else
      begin
         cfg_rdata <= {5'h00, hyst_sel_q, sensor_off_q, crit_lock_q, win_lock_q,
                       1'b0, alert_flag_q, alert_oe_q, crit_only_q, alert_pol_q,
                       alert_mode_q};
         temp_rdata <= {crit_alarm, high_alarm, low_alarm, temp_q};
      end
   end

endmodule // tacc_config_ctrl

`default_nettype wire

//--- pkg/tacc_map.vh
`ifndef TACC_MAP_VH
`define TACC_MAP_VH

// Configuration register field positions
`define TACC_CFG_HYST_HI 10
`define TACC_CFG_HYST_LO 9
`define TACC_CFG_OFF 8
`define TACC_CFG_CLOCK 7
`define TACC_CFG_WLOCK 6
`define TACC_CFG_REL 5
`define TACC_CFG_FLAG 4
`define TACC_CFG_OE 3
`define TACC_CFG_CRIT 2
`define TACC_CFG_POL 1
`define TACC_CFG_MODE 0
`define TACC_CFG_RSVD_HI 15
`define TACC_CFG_RSVD_LO 11

// Power-on values
`define TACC_RST_HYST 2'h0
`define TACC_RST_BIT 1'b0
`define TACC_RST_WORD 16'h0000

// Hysteresis select codes
`define TACC_HYST_OFF 2'h0
`define TACC_HYST_1P5 2'h1
`define TACC_HYST_3P0 2'h2
`define TACC_HYST_6P0 2'h3

// Hysteresis amounts in temperature LSBs of 1/16 degree
`define TACC_HYST_AMT_OFF 13'h0000
`define TACC_HYST_AMT_1P5 13'h0018
`define TACC_HYST_AMT_3P0 13'h0030
`define TACC_HYST_AMT_6P0 13'h0060

// Temperature register status positions
`define TACC_TMP_CRIT 15
`define TACC_TMP_HIGH 14
`define TACC_TMP_LOW 13
`define TACC_TMP_VAL_HI 12

// Width of the temperature value and of the limits
`define TACC_TEMP_W 13

`endif

//--- logic/tacc_alarm_cmp.v
`timescale 1ns/1ps
`default_nettype none

module tacc_alarm_cmp #(
   parameter W = 13,
   parameter LOWER = 0
) (
   input wire clk,
   input wire rst_n,
   input wire sample,
   input wire [W-1:0] temp,
   input wire [W-1:0] limit,
   input wire [W-1:0] hyst,
   output reg alarm_q
);

   wire signed [W:0] temp_s;
   wire signed [W:0] limit_s;
   wire signed [W:0] hyst_s;
   wire signed [W:0] release_s;
   reg alarm_d;

   assign temp_s = {temp[W-1], temp};
   assign limit_s = {limit[W-1], limit};
   assign hyst_s = {1'b0, hyst};
   // Hysteresis only lowers the threshold seen by falling temperature
   assign release_s = limit_s - hyst_s;

   always @*
   begin
      alarm_d = alarm_q;
      if (sample)
      begin
         if (LOWER != 0)
         begin
            // Entered by falling below limit minus hysteresis, left at the limit
            if (!alarm_q && (temp_s < release_s))
               alarm_d = 1'b1;
            else if (alarm_q && (temp_s >= limit_s))
               alarm_d = 1'b0;
         end
         else
         begin
            // Set above the plain limit, held until below limit minus hysteresis
            if (!alarm_q && (temp_s > limit_s))
               alarm_d = 1'b1;
            else if (alarm_q && (temp_s < release_s))
               alarm_d = 1'b0;
         end
      end
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         alarm_q <= 1'b0;
      else
         alarm_q <= alarm_d;
   end

endmodule // tacc_alarm_cmp

`default_nettype wire

//--- sim/tacc_config_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tacc_config_ctrl_chk (
   input wire mclk,
   input wire arst_n,
   input wire [15:0] cfg_rdata,
   input wire [15:0] temp_rdata,
   input wire conv_enable,
   input wire crit_trip_wr,
   input wire crit_trip_wr_ok,
   input wire window_trip_wr,
   input wire window_trip_wr_ok,
   input wire alert_o,
   input wire alert_oe_n
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   rsvd_zero_a: assert property (cfg_rdata[15:11] == 5'h00 && !cfg_rdata[5])
      else $error("reserved or release bit reads one");
   crit_gate_a: assert property (crit_trip_wr_ok |-> crit_trip_wr && !cfg_rdata[7])
      else $error("critical trip write passed while locked");
   win_gate_a: assert property (window_trip_wr_ok |-> window_trip_wr && !cfg_rdata[6])
      else $error("window trip write passed while locked");
   crit_stick_a: assert property (cfg_rdata[7] |=> cfg_rdata[7])
      else $error("critical lock cleared");
   win_stick_a: assert property (cfg_rdata[6] |=> cfg_rdata[6])
      else $error("window lock cleared");
   conv_en_a: assert property (cfg_rdata[8] == !$past(conv_enable))
      else $error("conversion enable disagrees with sensor off");
   flag_pin_a: assert property (cfg_rdata[4] == !$past(alert_oe_n))
      else $error("asserted flag disagrees with pin");
   off_quiet_a: assert property (cfg_rdata[8] || !cfg_rdata[3] |-> alert_oe_n)
      else $error("alert driven while off or disabled");
   pol_lvl_a: assert property (!alert_oe_n |=> cfg_rdata[1] == $past(alert_o))
      else $error("alert driven at wrong level");
   cmp_follow_a: assert property (!cfg_rdata[0] && cfg_rdata[3] && !cfg_rdata[8]
      && $stable(cfg_rdata) |-> alert_oe_n == !(cfg_rdata[2] ? temp_rdata[15]
      : |temp_rdata[15:13]))
      else $error("comparator pin does not follow alarms");
   cover property (!alert_oe_n && cfg_rdata[0]);
   cover property (cfg_rdata[7] && cfg_rdata[6]);
   cover property (cfg_rdata[8] && temp_rdata[14]);
endmodule // tacc_config_ctrl_chk
`default_nettype wire

//--- sim/tacc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tacc_host_model (
   input wire mclk,
   input wire alert_o,
   input wire alert_oe_n,
   output var logic cfg_wr,
   output var logic [15:0] cfg_wdata,
   output wire alert_pin
);
   // Released pin sits at the pull-up level
   assign alert_pin = alert_oe_n ? 1'b1 : alert_o;
   initial
   begin
      cfg_wr = 1'b0;
      cfg_wdata = 16'h5a5a;
   end
   task automatic wr(input logic [15:0] w);
      cfg_wdata = w & 16'h07ff;
      cfg_wr = 1'b1;
      @(negedge mclk);
      cfg_wr = 1'b0;
      cfg_wdata = ~cfg_wdata;
   endtask
endmodule // tacc_host_model
`default_nettype wire

//--- sim/tacc_config_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module tacc_config_ctrl_test;
   localparam [12:0] UP = 13'h0550;
   localparam [12:0] CR = 13'h05f0;
   localparam [12:0] LO = 13'h0100;
   localparam [12:0] MID = 13'h0300;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic temp_valid = 1'b0;
   logic [12:0] temp_sample = MID;
   logic crit_trip_wr = 1'b1;
   logic window_trip_wr = 1'b1;
   wire cfg_wr, alert_o, alert_oe_n, alert_pin, conv_enable, crit_trip_wr_ok, window_trip_wr_ok;
   wire [15:0] cfg_wdata, cfg_rdata, temp_rdata;
   logic [15:0] q[$];
   logic [15:0] w;
   logic [1:0] kind = 2'h0;
   logic [12:0] r;
   logic [12:0] hy [4] = '{13'h0000, 13'h0018, 13'h0030, 13'h0060};
   int seq = 0, seen = 0, err_count = 0, n_checks = 0, cyc = 0, k;
   always #25 mclk = ~mclk;
   always @(negedge mclk) temp_valid <= ~temp_valid;
   tacc_config_ctrl i_tacc_config_ctrl (.mclk(mclk), .arst_n(arst_n), .cfg_wr(cfg_wr),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .temp_valid(temp_valid),
      .temp_sample(temp_sample), .upper_limit(UP), .lower_limit(LO), .crit_limit(CR),
      .temp_rdata(temp_rdata), .conv_enable(conv_enable), .crit_trip_wr(crit_trip_wr),
      .crit_trip_wr_ok(crit_trip_wr_ok), .window_trip_wr(window_trip_wr),
      .window_trip_wr_ok(window_trip_wr_ok), .alert_i(alert_pin), .alert_o(alert_o),
      .alert_oe_n(alert_oe_n));
   tacc_host_model i_tacc_host_model (.mclk(mclk), .alert_o(alert_o),
      .alert_oe_n(alert_oe_n), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .alert_pin(alert_pin));
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input logic [15:0] s, input logic [15:0] e);
      n_checks++;
      if (s !== e)
      begin
         err_count++;
         $display("BAD t=%0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic see(input logic [1:0] k2, input logic [15:0] e);
      q.push_back(e);
      kind = k2;
      seq++;
      @(negedge mclk);
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic go(input logic [12:0] t);
      temp_sample = t;
      idle(5);
   endtask
   task automatic wrc(input logic [15:0] v);
      i_tacc_host_model.wr(v);
      idle(3);
   endtask
   // Status: alarm flags, asserted, polarity, sensor off, crit lock, window lock
   task automatic st(input logic [2:0] f, input logic a, p, o, c, l);
      see(2'h2, {8'h00, f, !a, a ? p : 1'b1, !o, !c, !l});
   endtask
   always @(posedge mclk)
   begin
      if (seq != seen)
      begin
         seen = seq;
         check(kind == 2'h1 ? cfg_rdata : {8'h00, temp_rdata[15:13], alert_oe_n, alert_pin,
            conv_enable, crit_trip_wr_ok, window_trip_wr_ok}, q.pop_front());
      end
   end
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         err_count++;
         summarize();
      end
   end
   initial
   begin
      r = 13'($urandom(32'ha601c467));
      idle(5);
      arst_n = 1'b1;
      idle(4);
      see(2'h1, 16'h0000);
      st(3'h0, 0, 0, 0, 0, 0);
      for (k = 0; k < 4; k++)
      begin
         r = 13'($urandom % 8);
         w = {5'h00, k[1:0], 9'h008};
         wrc(w);
         see(2'h1, w);
         go(UP);
         st(3'h0, 0, 0, 0, 0, 0);
         go(UP + 13'h001);
         st(3'h2, 1, 0, 0, 0, 0);
         see(2'h1, w | 16'h0010);
         go(UP - hy[k]);
         st(3'h2, 1, 0, 0, 0, 0);
         go(UP - hy[k] - 13'h001 - r);
         st(3'h0, 0, 0, 0, 0, 0);
         go(LO - hy[k]);
         st(3'h0, 0, 0, 0, 0, 0);
         go(LO - hy[k] - 13'h001);
         st(3'h1, 1, 0, 0, 0, 0);
         go(LO);
         st(3'h0, 0, 0, 0, 0, 0);
      end
      wrc(16'h000c);
      go(UP + 13'h001 + r);
      st(3'h2, 0, 0, 0, 0, 0);
      go(CR + 13'h001);
      st(3'h6, 1, 0, 0, 0, 0);
      go(MID);
      wrc(16'h000a);
      go(UP + 13'h001);
      st(3'h2, 1, 1, 0, 0, 0);
      go(MID);
      wrc(16'h0009);
      go(UP + 13'h001);
      go(MID);
      st(3'h0, 1, 0, 0, 0, 0);
      wrc(16'h0029);
      see(2'h1, 16'h0009);
      st(3'h0, 0, 0, 0, 0, 0);
      wrc(16'h0008);
      go(UP + 13'h001);
      wrc(16'h0028);
      st(3'h2, 1, 0, 0, 0, 0);
      wrc(16'h0108);
      go(MID);
      st(3'h2, 0, 0, 1, 0, 0);
      see(2'h1, 16'h0108);
      wrc(16'h0008);
      go(MID);
      st(3'h0, 0, 0, 0, 0, 0);
      wrc(16'h0080);
      st(3'h0, 0, 0, 0, 1, 0);
      wrc(16'h070f);
      see(2'h1, 16'h0084);
      wrc(16'h0040);
      see(2'h1, 16'h00c0);
      st(3'h0, 0, 0, 0, 1, 1);
      wrc(16'h0004);
      see(2'h1, 16'h00c0);
      arst_n = 1'b0;
      idle(2);
      arst_n = 1'b1;
      idle(4);
      see(2'h1, 16'h0000);
      summarize();
   end
endmodule // tacc_config_ctrl_test
bind tacc_config_ctrl tacc_config_ctrl_chk i_chk (.mclk(mclk), .arst_n(arst_n),
   .cfg_rdata(cfg_rdata), .temp_rdata(temp_rdata), .conv_enable(conv_enable),
   .crit_trip_wr(crit_trip_wr), .crit_trip_wr_ok(crit_trip_wr_ok),
   .window_trip_wr(window_trip_wr), .window_trip_wr_ok(window_trip_wr_ok),
   .alert_o(alert_o), .alert_oe_n(alert_oe_n));
`default_nettype wire
